// File: tb/llatu_mem_model.sv
/*
 * Table memory on the walk port, answering after a set delay.
 * Assumes four-byte entries per page from table_ptr_in.
 */
`timescale 1ns/100ps
`default_nettype none

module llatu_mem_model (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic arst_n_in,
    // Walk port
    input wire logic mem_rd_in,
    input wire logic [31:0] mem_addr_in,
    output logic [31:0] mem_data_out,
    output logic mem_ack_out,
    // Setup
    input wire logic [31:0] table_ptr_in,
    input wire logic [2:0] delay_in
);
    logic [2:0] cnt_q;
    logic [31:0] page;

    // Scrambled frame; pages ending 3f invalid, bit 8 system-only, bit 9 I/O
    function automatic logic [31:0] pte_of(input logic [21:0] pg);
        pte_of = {pg ^ 22'h15_a5a5, 7'h00, pg[9], pg[8], pg[5:0] != 6'h3f};
    endfunction

    assign page = (mem_addr_in - table_ptr_in) >> 2;

    // Data toggles outside the answer so a stale word is never reused
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= 3'h0;
            mem_ack_out <= 1'h0;
            mem_data_out <= 32'h0000_0000;
        end else begin
            mem_ack_out <= 1'h0;
            mem_data_out <= ~mem_data_out;
            if (mem_rd_in && !mem_ack_out) begin
                cnt_q <= cnt_q + 3'h1;
                if (cnt_q == delay_in) begin
                    mem_ack_out <= 1'h1;
                    mem_data_out <= pte_of(page[21:0]);
                    cnt_q <= 3'h0;
                end
            end else begin
                cnt_q <= 3'h0;
            end
        end
    end
endmodule

`default_nettype wire

// File: tb/llatu_properties.sv
/*
 * Port checker of the translation unit.
 * Assumes a bind from the bench.
 */
`timescale 1ns/100ps
`default_nettype none

module llatu_properties (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic arst_n_in,
    // Watched ports
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic xl_req_in,
    input wire logic xl_io_in,
    input wire logic xl_busy_out,
    input wire logic xl_done_out,
    input wire logic xl_fault_out,
    input wire logic mem_rd_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic mem_ack_in,
    input wire logic syscall_in,
    input wire logic trap_out,
    input wire logic sys_mode_out
);
    default clocking dc @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);

    chk_req_busy: assert property (xl_req_in && !xl_busy_out && !xl_io_in |=> xl_busy_out)
        else $error("busy missing");
    chk_busy_done: assert property ($rose(xl_busy_out) |-> ##[1:40] xl_done_out)
        else $error("done missing");
    chk_done_once: assert property (xl_done_out |=> !xl_done_out)
        else $error("done too long");
    chk_fault_done: assert property (xl_fault_out |-> xl_done_out)
        else $error("fault alone");
    chk_walk_hold: assert property (mem_rd_out && !mem_ack_in |=> mem_rd_out && $stable(mem_addr_out))
        else $error("walk read dropped");
    chk_walk_end: assert property (mem_rd_out && mem_ack_in |-> ##1 !mem_rd_out ##[0:1] xl_done_out)
        else $error("walk did not finish");
    chk_fault_trap: assert property (xl_fault_out |-> ##[0:1] trap_out)
        else $error("fault without trap");
    chk_syscall_trap: assert property (syscall_in |=> trap_out)
        else $error("syscall no trap");
    chk_trap_sys: assert property (trap_out |-> ##[0:1] sys_mode_out)
        else $error("trap left normal mode");
    chk_io_refuse: assert property (xl_req_in && !xl_busy_out && xl_io_in && !sys_mode_out && !trap_out |=> xl_done_out && xl_fault_out)
        else $error("io not refused");
    chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
        else $error("stray read data");

    cov_walk: cover property (mem_rd_out && mem_ack_in);
    cov_fault: cover property (xl_fault_out);
    cov_syscall: cover property (syscall_in ##1 trap_out);
endmodule

`default_nettype wire

// File: tb/tb.sv
/*
 * Bench for the translation unit.
 * Assumes the table model and bound checker.
 */
`timescale 1ns/100ps
`default_nettype none
`include "llatu_consts.vh"

module tb;
    logic mclk_in, arst_n_in, reg_wr_in, reg_rd_in, xl_req_in, xl_io_in, mem_ack_in;
    logic syscall_in, exc_in, xl_busy_out, xl_done_out, xl_fault_out, xl_phys_io_out;
    logic mem_rd_out, trap_out, sys_mode_out, walked, flt;
    logic [7:0] reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, xl_base_in, xl_disp_in, xl_phys_out;
    logic [31:0] mem_addr_out, mem_data_in, sp_out, tptr, rv;
    logic [2:0] mdelay;
    int bad_count, n_compared;

    llatu_top uut (.*);
    llatu_mem_model mem (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .mem_rd_in(mem_rd_out),
        .mem_addr_in(mem_addr_out), .mem_data_out(mem_data_in), .mem_ack_out(mem_ack_in),
        .table_ptr_in(tptr), .delay_in(mdelay));

    initial begin
        mclk_in = 1'h0;
        forever #5 mclk_in = ~mclk_in;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'h1;
        @(posedge mclk_in);
        reg_wr_in <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'h1;
        @(posedge mclk_in);
        reg_rd_in <= 1'h0;
        #1 rv = reg_rdata_out;
    endtask

    task automatic pulse(input logic sc);
        @(posedge mclk_in);
        syscall_in <= sc;
        exc_in <= !sc;
        @(posedge mclk_in);
        syscall_in <= 1'h0;
        exc_in <= 1'h0;
    endtask

    function automatic logic [31:0] laddr(input logic [1:0] md, input logic [31:0] b,
                                          input logic [31:0] d, input logic [15:0] pch);
        logic [31:0] s;
        s = b + d;
        if (md == `LLATU_MODE_COMPACT) laddr = {pch, s[15:0]};
        else if (md == `LLATU_MODE_SEG) laddr = b[31] ? {b[31:24], s[23:0]} : {b[31:16], s[15:0]};
        else laddr = s;
    endfunction

    // Frame from the model's table
    task automatic xlate(input logic [31:0] la, input logic [31:0] b, input logic [31:0] d,
                         input logic io, input logic ef);
        logic [31:0] pte, wa;
        int n;
        pte = mem.pte_of(la[31:10]);
        walked = 1'h0;
        wa = 32'h0000_0000;
        @(posedge mclk_in);
        mdelay <= $urandom_range(5);
        xl_req_in <= 1'h1;
        xl_base_in <= b;
        xl_disp_in <= d;
        xl_io_in <= io;
        @(posedge mclk_in);
        xl_req_in <= 1'h0;
        #1;
        for (n = 0; n < 40 && xl_done_out !== 1'h1; n++) begin
            @(negedge mclk_in);
            if (mem_rd_out === 1'h1) begin
                walked = 1'h1;
                wa = mem_addr_out;
            end
        end
        flt = xl_fault_out;
        check("fault", flt, ef);
        if (walked) check("walk addr", wa, tptr + {la[31:10], 2'h0});
        if (!flt) check("phys", xl_phys_out, {pte[31:10], la[9:0]});
        if (!flt) check("phys io", xl_phys_io_out, pte[2] | io);
    endtask

    task automatic print_verdict;
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk_in);
        bad_count++;
        print_verdict();
    end

    initial begin
        logic [15:0] pch;
        logic [31:0] b, d, la;
        int i, m;
        {arst_n_in, reg_wr_in, reg_rd_in, xl_req_in, xl_io_in, syscall_in, exc_in} = 7'h00;
        {reg_addr_in, reg_wdata_in, xl_base_in, xl_disp_in, mdelay} = '0;
        tptr = 32'h0010_0000;
        void'($urandom(32'h0000_efd0));
        repeat (10) @(posedge mclk_in);
        arst_n_in <= 1'h1;
        @(posedge mclk_in);
        check("reset mode", sys_mode_out, 1);
        rd(`LLATU_REG_FCW);
        check("reset fcw", rv, 32'h0000_4000);
        rd(8'hfc);
        check("unmapped", rv, 0);
        wr(`LLATU_REG_TPTR, tptr);
        for (m = 0; m < 4; m++) begin
            wr(`LLATU_REG_FCW, 32'h0000_4000 | (m << 12));
            for (i = 0; i < 8; i++) begin
                pch = $urandom;
                b = $urandom;
                d = (i < 2) ? 32'h0000_ffff : $urandom;
                wr(`LLATU_REG_PC, {pch, 16'h0000});
                la = laddr(m[1:0], b, d, pch);
                xlate(la, b, d, i[0], la[15:10] == 6'h3f);
                if (!flt) xlate(la, b, d, i[0], 1'h0);
                if (!flt) check("tlb hit", walked, 0);
            end
        end
        wr(`LLATU_REG_TLBCTL, 32'h0000_0001);
        wr(`LLATU_REG_FCW, 32'h0000_6000);
        // Fill, touch page 0, evict the oldest
        for (i = 0; i < 20; i++) begin
            m = (i < 16) ? i : (i == 17) ? 16 : (i == 19) ? 1 : 0;
            la = 32'h0100_0000 + (m << 10);
            xlate(la, la, 32'h0000_0000, 1'h0, 1'h0);
            check("lru walk", walked, i < 16 || i == 17 || i == 19);
        end
        wr(`LLATU_REG_SSP, 32'h0000_a000);
        wr(`LLATU_REG_NSP, 32'h0000_5000);
        @(posedge mclk_in);
        check("system sp", sp_out, 32'h0000_a000);
        wr(`LLATU_REG_PC, 32'h0123_4000);
        wr(`LLATU_REG_FCW, 32'h0000_2000);
        repeat (2) @(posedge mclk_in);
        check("normal mode", sys_mode_out, 0);
        check("normal sp", sp_out, 32'h0000_5000);
        la = 32'h0104_0000;
        xlate(la, la, 32'h0000_0000, 1'h0, 1'h1);
        rd(`LLATU_REG_CAUSE);
        check("cause xlate", rv, 1);
        rd(`LLATU_REG_FAULT);
        check("fault addr", rv, la);
        rd(`LLATU_REG_SPC);
        check("saved pc", rv, 32'h0123_4000);
        rd(`LLATU_REG_SFCW);
        check("saved fcw", rv, 32'h0000_2000);
        xlate(la, la, 32'h0000_0000, 1'h0, 1'h0);
        // Normal mode refusals and a system call
        for (m = 0; m < 3; m++) begin
            wr(`LLATU_REG_FCW, 32'h0000_2000);
            repeat (2) @(posedge mclk_in);
            if (m == 0) wr(`LLATU_REG_TPTR, 32'h0000_0000);
            if (m == 1) xlate(la, la, 32'h0000_0000, 1'h1, 1'h1);
            if (m == 2) pulse(1'h1);
            #1;
            if (m != 1) check("trap", trap_out, 1);
            rd(m == 0 ? `LLATU_REG_TPTR : `LLATU_REG_CAUSE);
            if (m != 1) check("refused", rv, m == 0 ? tptr : 3);
            check("back to system", sys_mode_out, 1);
        end
        wr(`LLATU_REG_FCW, 32'h0000_5000);
        pulse(1'h0);
        #1;
        check("ext trap", trap_out, 1);
        rd(`LLATU_REG_CAUSE);
        check("cause ext", rv, 4);
        rd(`LLATU_REG_SFCW);
        check("saved fcw ext", rv, 32'h0000_5000);
        print_verdict();
    end
endmodule

bind llatu_top llatu_properties chk (.*);

`default_nettype wire

// File: verilog/llatu_addr_gen.v
/*
 * Logical address former for the three representations.
 * Assumes operands stable while sampled.
 */
`timescale 1ns/100ps
`default_nettype none
`include "llatu_consts.vh"

module llatu_addr_gen (
    // Mode and operands
    input wire [1:0] mode_in,
    input wire [31:0] base_in,
    input wire [31:0] disp_in,
    input wire [15:0] pc_hi_in,
    // Result
    output reg [31:0] laddr_out
);
    reg [15:0] sum16;
    reg [23:0] sum24;
    reg [31:0] sum32;

    always @* begin
        sum16 = base_in[15:0] + disp_in[15:0];
        sum24 = base_in[23:0] + disp_in[23:0];
        sum32 = base_in + disp_in;
        case (mode_in)
            `LLATU_MODE_COMPACT: begin
                laddr_out = {pc_hi_in, sum16};
            end
            `LLATU_MODE_SEG: begin
                // Carry stops at the offset, the segment number is kept
                if (base_in[31]) begin
                    laddr_out = {base_in[31:24], sum24};
                end else begin
                    laddr_out = {base_in[31:16], sum16};
                end
            end
            default: begin
                laddr_out = sum32;
            end
        endcase
    end
endmodule
`default_nettype wire

// File: verilog/llatu_consts.vh
/*
 * Translation unit constants: offsets, fields, causes.
 * Assumes an 8-bit byte register address.
 */
`ifndef LLATU_CONSTS_VH
`define LLATU_CONSTS_VH

// Register byte offsets
`define LLATU_REG_FCW 8'h00
`define LLATU_REG_PC 8'h04
`define LLATU_REG_SP 8'h08
`define LLATU_REG_NSP 8'h0c
`define LLATU_REG_SSP 8'h10
`define LLATU_REG_TPTR 8'h14
`define LLATU_REG_SPC 8'h18
`define LLATU_REG_SFCW 8'h1c
`define LLATU_REG_CAUSE 8'h20
`define LLATU_REG_FAULT 8'h24
`define LLATU_REG_TLBCTL 8'h28

// Flag and control word fields
`define LLATU_FCW_SYS 14
`define LLATU_FCW_MODE_HI 13
`define LLATU_FCW_MODE_LO 12
`define LLATU_FCW_RST 16'h4000
`define LLATU_MODE_COMPACT 2'h0
`define LLATU_MODE_SEG 2'h1
`define LLATU_MODE_LIN 2'h2

// Paging
`define LLATU_PAGE_BITS 10
`define LLATU_PTE_VALID 0
`define LLATU_PTE_SYS 1
`define LLATU_PTE_IO 2

// Trap causes
`define LLATU_CAUSE_NONE 3'h0
`define LLATU_CAUSE_XLATE 3'h1
`define LLATU_CAUSE_PRIV 3'h2
`define LLATU_CAUSE_SYSCALL 3'h3
`define LLATU_CAUSE_EXT 3'h4

// Reset values
`define LLATU_ZERO32 32'h0000_0000

`endif

// File: verilog/llatu_tlb_entry.v
/*
 * One lookaside buffer entry with its match.
 * Assumes one clock, async active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module llatu_tlb_entry #(
    parameter TAG_W = 22,
    parameter FRM_W = 22
) (
    // Clock and reset
    input wire clk_in,
    input wire arst_n_in,
    // Maintenance
    input wire flush_in,
    input wire load_in,
    input wire [TAG_W-1:0] tag_in,
    input wire [FRM_W-1:0] frame_in,
    input wire sys_in,
    input wire io_in,
    // Lookup
    input wire [TAG_W-1:0] look_tag_in,
    output wire hit_out,
    output wire [FRM_W-1:0] frame_out,
    output wire sys_out,
    output wire io_out
);
    reg valid_q;
    reg [TAG_W-1:0] tag_q;
    reg [FRM_W-1:0] frame_q;
    reg sys_q;
    reg io_q;

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            valid_q <= 1'b0;
            tag_q <= {TAG_W{1'b0}};
            frame_q <= {FRM_W{1'b0}};
            sys_q <= 1'b0;
            io_q <= 1'b0;
        end else if (flush_in) begin
            valid_q <= 1'b0;
        end else if (load_in) begin
            valid_q <= 1'b1;
            tag_q <= tag_in;
            frame_q <= frame_in;
            sys_q <= sys_in;
            io_q <= io_in;
        end
    end

    assign hit_out = valid_q && (tag_q == look_tag_in);
    assign frame_out = frame_q;
    assign sys_out = sys_q;
    assign io_out = io_q;
endmodule
`default_nettype wire

// File: verilog/llatu_top.v
/*
 * Translation unit: address forming, privilege state,
 * sixteen-entry lookaside buffer with hardware walk,
 * program status save on traps.
 * Assumes a table read port that acknowledges.
 */
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "llatu_consts.vh"

// How it works
// - Every 32-bit logical address is translated before memory or I/O access.
// - Two flag and control word bits pick compact, segmented or linear mode.
// - Compact mode prefixes program counter upper half to the 16-bit address.
// - Segmented mode has 32768 small 64K segments and 128 large 16M segments.
// - Segmented arithmetic never changes the segment number, carries stay in offset.
// - Linear mode uses the full 32-bit value as one flat address.
// - Pages and frames are 1K bytes; low ten bits pass untranslated.
// - Any page may map to any frame.
// - Sixteen recently used translations are held and consulted before tables.
// - A miss walks the memory table in hardware and installs the result.
// - The walk uses the privileged table pointer register.
// - A translation may mark its frame as physical I/O space.
// - System-only pages are refused to normal mode accesses.
// - One flag and control word bit gives normal or system mode.
// - I/O accesses and control registers are refused in normal mode.
// - Separate normal and system stack pointers, selected by mode.
// - A system call traps a normal program into system mode.
// - Any trap saves the 32-bit program counter and 16-bit flag word.
// - Failed translation or protection violation raises a translation trap.
module llatu_top #(
    parameter ENTRIES = 16,
    parameter IDX_W = 4
) (
    // Clock and reset
    input wire mclk_in,
    input wire arst_n_in,
    // Register port
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    // Translation request
    input wire xl_req_in,
    input wire [31:0] xl_base_in,
    input wire [31:0] xl_disp_in,
    input wire xl_io_in,
    output reg xl_busy_out,
    output reg xl_done_out,
    output reg xl_fault_out,
    output reg [31:0] xl_phys_out,
    output reg xl_phys_io_out,
    // Table walk memory port
    output reg mem_rd_out,
    output reg [31:0] mem_addr_out,
    input wire [31:0] mem_data_in,
    input wire mem_ack_in,
    // Exceptions and status
    input wire syscall_in,
    input wire exc_in,
    output reg trap_out,
    output reg sys_mode_out,
    output reg [31:0] sp_out
);
    localparam ST_IDLE = 2'b00;
    localparam ST_LOOK = 2'b01;
    localparam ST_WALK = 2'b10;
    localparam TAG_W = 32 - `LLATU_PAGE_BITS;

    reg [1:0] st_q;
    reg [15:0] fcw_q;
    reg [31:0] pc_q;
    reg [31:0] nsp_q;
    reg [31:0] ssp_q;
    reg [31:0] tptr_q;
    reg [31:0] spc_q;
    reg [15:0] sfcw_q;
    reg [2:0] cause_q;
    reg [31:0] fault_q;
    reg [31:0] lad_q;
    reg acc_io_q;
    reg [IDX_W-1:0] age_q [0:ENTRIES-1];

    wire sys_mode = fcw_q[`LLATU_FCW_SYS];
    wire [31:0] laddr;
    wire [ENTRIES-1:0] hit_vec;
    wire [TAG_W-1:0] ent_frame [0:ENTRIES-1];
    wire [ENTRIES-1:0] ent_sys;
    wire [ENTRIES-1:0] ent_io;
    wire [ENTRIES-1:0] load_vec;
    wire flush;

    // Address formation for the current representation
    llatu_addr_gen u_agen (
        .mode_in(fcw_q[`LLATU_FCW_MODE_HI:`LLATU_FCW_MODE_LO]),
        .base_in(xl_base_in),
        .disp_in(xl_disp_in),
        .pc_hi_in(pc_q[31:16]),
        .laddr_out(laddr)
    );

    reg any_hit;
    reg [IDX_W-1:0] hit_idx;
    reg [TAG_W-1:0] hit_frame;
    reg hit_sys;
    reg hit_io;
    reg [IDX_W-1:0] victim;
    integer k;

    // Entry select and least recently used victim
    always @* begin
        any_hit = 1'b0;
        hit_idx = {IDX_W{1'b0}};
        hit_frame = {TAG_W{1'b0}};
        hit_sys = 1'b0;
        hit_io = 1'b0;
        victim = {IDX_W{1'b0}};
        for (k = 0; k < ENTRIES; k = k + 1) begin
            if (hit_vec[k]) begin
                any_hit = 1'b1;
                hit_idx = k[IDX_W-1:0];
                hit_frame = ent_frame[k];
                hit_sys = ent_sys[k];
                hit_io = ent_io[k];
            end
            if (age_q[k] == {IDX_W{1'b1}}) begin
                victim = k[IDX_W-1:0];
            end
        end
    end

    // Event decode
    wire reg_acc = reg_wr_in | reg_rd_in;
    wire unpriv_reg = (reg_addr_in == `LLATU_REG_PC) || (reg_addr_in == `LLATU_REG_SP);
    wire priv_reg = reg_acc && !unpriv_reg && !sys_mode;
    wire priv_io = (st_q == ST_IDLE) && xl_req_in && xl_io_in && !sys_mode;
    wire look_fault = (st_q == ST_LOOK) && any_hit && hit_sys && !sys_mode;
    wire walk_fault = (st_q == ST_WALK) && mem_ack_in &&
        !mem_data_in[`LLATU_PTE_VALID];
    wire xl_fault = look_fault || walk_fault;
    wire trap_ev = xl_fault || priv_reg || priv_io || syscall_in || exc_in;
    wire walk_load = (st_q == ST_WALK) && mem_ack_in && mem_data_in[`LLATU_PTE_VALID];
    wire look_ok = (st_q == ST_LOOK) && any_hit && !look_fault;
    wire sys_wr = reg_wr_in && sys_mode;

    // New table pointer drops stale entries
    assign flush = sys_wr && ((reg_addr_in == `LLATU_REG_TPTR) ||
        ((reg_addr_in == `LLATU_REG_TLBCTL) && reg_wdata_in[0]));

    genvar g;
    generate
        for (g = 0; g < ENTRIES; g = g + 1) begin : g_ent
            assign load_vec[g] = walk_load && (victim == g);
            llatu_tlb_entry #(
                .TAG_W(TAG_W),
                .FRM_W(TAG_W)
            ) u_ent (
                .clk_in(mclk_in),
                .arst_n_in(arst_n_in),
                .flush_in(flush),
                .load_in(load_vec[g]),
                .tag_in(lad_q[31:`LLATU_PAGE_BITS]),
                .frame_in(mem_data_in[31:`LLATU_PAGE_BITS]),
                .sys_in(mem_data_in[`LLATU_PTE_SYS]),
                .io_in(mem_data_in[`LLATU_PTE_IO]),
                .look_tag_in(lad_q[31:`LLATU_PAGE_BITS]),
                .hit_out(hit_vec[g]),
                .frame_out(ent_frame[g]),
                .sys_out(ent_sys[g]),
                .io_out(ent_io[g])
            );
        end
    endgenerate

    // Ages form a permutation; oldest is the victim
    wire touch = look_ok || walk_load;
    wire [IDX_W-1:0] touch_idx = look_ok ? hit_idx : victim;
    wire [IDX_W-1:0] touch_age = age_q[touch_idx];
    integer i;

    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (i = 0; i < ENTRIES; i = i + 1) begin
                age_q[i] <= i[IDX_W-1:0];
            end
        end else if (flush) begin
            for (i = 0; i < ENTRIES; i = i + 1) begin
                age_q[i] <= i[IDX_W-1:0];
            end
        end else if (touch) begin
            for (i = 0; i < ENTRIES; i = i + 1) begin
                if (i[IDX_W-1:0] == touch_idx) begin
                    age_q[i] <= {IDX_W{1'b0}};
                end else if (age_q[i] < touch_age) begin
                    age_q[i] <= age_q[i] + 1'b1;
                end
            end
        end
    end

    // Translation sequencer
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q <= ST_IDLE;
            lad_q <= `LLATU_ZERO32;
            acc_io_q <= 1'b0;
            xl_busy_out <= 1'b0;
            xl_done_out <= 1'b0;
            xl_fault_out <= 1'b0;
            xl_phys_out <= `LLATU_ZERO32;
            xl_phys_io_out <= 1'b0;
            mem_rd_out <= 1'b0;
            mem_addr_out <= `LLATU_ZERO32;
        end else begin
            xl_done_out <= 1'b0;
            xl_fault_out <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (xl_req_in && priv_io) begin
                        xl_done_out <= 1'b1;
                        xl_fault_out <= 1'b1;
                    end else if (xl_req_in) begin
                        lad_q <= laddr;
                        acc_io_q <= xl_io_in;
                        xl_busy_out <= 1'b1;
                        st_q <= ST_LOOK;
                    end
                end
                ST_LOOK: begin
                    if (look_fault) begin
                        xl_done_out <= 1'b1;
                        xl_fault_out <= 1'b1;
                        xl_busy_out <= 1'b0;
                        st_q <= ST_IDLE;
                    end else if (any_hit) begin
                        // Offset bits bypass the buffer unchanged
                        xl_phys_out <= {hit_frame, lad_q[`LLATU_PAGE_BITS-1:0]};
                        xl_phys_io_out <= hit_io || acc_io_q;
                        xl_done_out <= 1'b1;
                        xl_busy_out <= 1'b0;
                        st_q <= ST_IDLE;
                    end else begin
                        mem_rd_out <= 1'b1;
                        mem_addr_out <= tptr_q +
                            {8'h00, lad_q[31:`LLATU_PAGE_BITS], 2'b00};
                        st_q <= ST_WALK;
                    end
                end
                ST_WALK: begin
                    if (mem_ack_in) begin
                        mem_rd_out <= 1'b0;
                        if (walk_fault) begin
                            xl_done_out <= 1'b1;
                            xl_fault_out <= 1'b1;
                            xl_busy_out <= 1'b0;
                            st_q <= ST_IDLE;
                        end else begin
                            // Retry the lookup; it now hits the new entry
                            st_q <= ST_LOOK;
                        end
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                    xl_busy_out <= 1'b0;
                    mem_rd_out <= 1'b0;
                end
            endcase
        end
    end

    // Architectural registers and trap entry
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fcw_q <= `LLATU_FCW_RST;
            pc_q <= `LLATU_ZERO32;
            nsp_q <= `LLATU_ZERO32;
            ssp_q <= `LLATU_ZERO32;
            tptr_q <= `LLATU_ZERO32;
            spc_q <= `LLATU_ZERO32;
            sfcw_q <= 16'h0000;
            cause_q <= `LLATU_CAUSE_NONE;
            fault_q <= `LLATU_ZERO32;
            trap_out <= 1'b0;
        end else begin
            trap_out <= trap_ev;
            if (reg_wr_in && !priv_reg) begin
                case (reg_addr_in)
                    `LLATU_REG_FCW: fcw_q <= reg_wdata_in[15:0];
                    `LLATU_REG_PC: pc_q <= reg_wdata_in;
                    `LLATU_REG_SP: begin
                        if (sys_mode) begin
                            ssp_q <= reg_wdata_in;
                        end else begin
                            nsp_q <= reg_wdata_in;
                        end
                    end
                    `LLATU_REG_NSP: nsp_q <= reg_wdata_in;
                    `LLATU_REG_SSP: ssp_q <= reg_wdata_in;
                    `LLATU_REG_TPTR: tptr_q <= reg_wdata_in;
                    `LLATU_REG_SPC: spc_q <= reg_wdata_in;
                    `LLATU_REG_SFCW: sfcw_q <= reg_wdata_in[15:0];
                    default: begin
                    end
                endcase
            end
            // Trap beats a same-cycle write
            if (trap_ev) begin
                spc_q <= pc_q;
                sfcw_q <= fcw_q;
                fcw_q[`LLATU_FCW_SYS] <= 1'b1;
                if (xl_fault) begin
                    cause_q <= `LLATU_CAUSE_XLATE;
                    fault_q <= lad_q;
                end else if (priv_reg || priv_io) begin
                    cause_q <= `LLATU_CAUSE_PRIV;
                end else if (syscall_in) begin
                    cause_q <= `LLATU_CAUSE_SYSCALL;
                end else begin
                    cause_q <= `LLATU_CAUSE_EXT;
                end
            end
        end
    end

    // Status outputs, one cycle behind
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sys_mode_out <= 1'b1;
            sp_out <= `LLATU_ZERO32;
        end else begin
            sys_mode_out <= sys_mode;
            sp_out <= sys_mode ? ssp_q : nsp_q;
        end
    end

    // Refused or unmapped reads give zero
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= `LLATU_ZERO32;
        end else if (reg_rd_in && !priv_reg) begin
            case (reg_addr_in)
                `LLATU_REG_FCW: reg_rdata_out <= {16'h0000, fcw_q};
                `LLATU_REG_PC: reg_rdata_out <= pc_q;
                `LLATU_REG_SP: reg_rdata_out <= sys_mode ? ssp_q : nsp_q;
                `LLATU_REG_NSP: reg_rdata_out <= nsp_q;
                `LLATU_REG_SSP: reg_rdata_out <= ssp_q;
                `LLATU_REG_TPTR: reg_rdata_out <= tptr_q;
                `LLATU_REG_SPC: reg_rdata_out <= spc_q;
                `LLATU_REG_SFCW: reg_rdata_out <= {16'h0000, sfcw_q};
                `LLATU_REG_CAUSE: reg_rdata_out <= {29'h0000_0000, cause_q};
                `LLATU_REG_FAULT: reg_rdata_out <= fault_q;
                default: reg_rdata_out <= `LLATU_ZERO32;
            endcase
        end else begin
            reg_rdata_out <= `LLATU_ZERO32;
        end
    end
endmodule
`default_nettype wire
